// ### src/trgsup_consts.vh
// Constants for the trigger supervisor core: widths, codes, timing.
// Assumes inclusion by the core under src/ and by the front-end model and bench under verif/.
`ifndef TRGSUP_CONSTS_VH
`define TRGSUP_CONSTS_VH
`define TRGSUP_N_GLOBAL     30
`define TRGSUP_N_FPSYNC     30
`define TRGSUP_N_FPASYNC    15
`define TRGSUP_N_PRIM       75
`define TRGSUP_WORD_W       16
`define TRGSUP_TYPE_W       8
`define TRGSUP_SRC_W        3
`define TRGSUP_PS_W         16
`define TRGSUP_CLK_MHZ      250
`define TRGSUP_SER_MHZ      62
`define TRGSUP_SER_DIV      4
`define TRGSUP_SER_DIV_W    2
`define TRGSUP_FIFO_DEPTH   8
`define TRGSUP_FIFO_AW      3
// Trigger word fields
`define TRGSUP_TYPE_LSB     0
`define TRGSUP_SRC_LSB      8
`define TRGSUP_HDR_LSB      11
`define TRGSUP_HDR_W        5
`define TRGSUP_HDR_TRIG     5'h1c
`define TRGSUP_HDR_SYNC     5'h1e
// Source codes
`define TRGSUP_SRC_GLOBAL   3'h1
`define TRGSUP_SRC_FPSYNC   3'h2
`define TRGSUP_SRC_FPASYNC  3'h3
`define TRGSUP_SRC_CAL      3'h4
`define TRGSUP_SRC_RAND     3'h5
`define TRGSUP_SRC_FIXED    3'h6
// Resets and timing
`define TRGSUP_LFSR_SEED    16'hace1
`define TRGSUP_PULSE_CYC    3'h4
`define TRGSUP_PULSE_CYC_W  3
`endif

// ### src/trgsup_core.v
// Trigger supervisor core: sync, prescale, trigger forming, dead time,
// trigger word FIFO and serializer, alignment pulse, clock select.
// Assumes i_clk is the selected 250 MHz system clock; pins asynchronous.
`timescale 1ns/10ps
`include "trgsup_consts.vh"
module trgsup_core (
  // Clock and reset
  input  wire                        i_clk,
  input  wire                        i_rst_n,
  // Trigger primitives
  input  wire [`TRGSUP_N_GLOBAL-1:0]  i_global_trig,
  input  wire [1:0]                   i_global_clk,
  input  wire [`TRGSUP_N_FPSYNC-1:0]  i_fpsync_trig,
  input  wire [1:0]                   i_fpsync_clk,
  input  wire [`TRGSUP_N_FPASYNC-1:0] i_fpasync_trig,
  // Control
  input  wire [`TRGSUP_N_PRIM-1:0]    i_prim_enable,
  input  wire [`TRGSUP_PS_W-1:0]      i_prescale,
  input  wire [`TRGSUP_TYPE_W-1:0]    i_trig_type,
  input  wire                         i_cal_cmd,
  input  wire                         i_rand_enable,
  input  wire [15:0]                  i_rand_thresh,
  input  wire                         i_fixed_start,
  input  wire [15:0]                  i_fixed_count,
  input  wire                         i_sync_cmd,
  input  wire                         i_busy,
  input  wire                         i_busy_stop,
  input  wire [15:0]                  i_busy_hold,
  input  wire                         i_inhibit,
  input  wire                         i_clk_src_ext,
  input  wire                         i_pulse_mode,
  // Outputs
  output reg  [3:0]                   o_ser_nib,
  output reg                          o_ser_frame,
  output reg                          o_align_pulse,
  output reg                          o_clk_sel_ext,
  output reg                          o_bp_trig_pulse,
  output reg                          o_trig_event,
  output reg                          o_trig_lost,
  output reg                          o_fifo_full,
  output reg  [31:0]                  o_dead_count,
  output reg  [31:0]                  o_event_count
);
  localparam NP      = `TRGSUP_N_PRIM;
  localparam NASYNC  = `TRGSUP_N_FPASYNC + 7;
  localparam SER_DIV = `TRGSUP_CLK_MHZ / `TRGSUP_SER_MHZ;
  localparam FX_IDLE = 1'b0;
  localparam FX_RUN  = 1'b1;

  // Front-panel async triggers and the command, mode and busy pin levels, two flops deep
  wire [NASYNC-1:0] async_in;
  reg  [NASYNC-1:0] meta_ff;
  reg  [NASYNC-1:0] sync_ff;
  assign async_in = {i_clk_src_ext, i_sync_cmd, i_fixed_start, i_cal_cmd,
                     i_busy, i_inhibit, i_pulse_mode, i_fpasync_trig};
  wire [NP-1:0] prim_raw;
  reg  [NP-1:0] prim_meta_ff;
  reg  [NP-1:0] prim_sync_ff;
  reg  [NP-1:0] prim_prev_ff;
  wire [NP-1:0] prim_edge;
  wire [NP-1:0] prim_ps;

  // Global and front-panel sync triggers are aligned to the system clock
  // domain here by their own two-flop stage, prim_meta_ff then prim_sync_ff
  assign prim_raw = {sync_ff[`TRGSUP_N_FPASYNC-1:0],
                     i_fpsync_trig, i_global_trig};

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_ff      <= {NASYNC{1'b0}};
      sync_ff      <= {NASYNC{1'b0}};
      prim_meta_ff <= {NP{1'b0}};
      prim_sync_ff <= {NP{1'b0}};
      prim_prev_ff <= {NP{1'b0}};
    end else begin
      meta_ff      <= async_in;
      sync_ff      <= meta_ff;
      prim_meta_ff <= {{`TRGSUP_N_FPASYNC{1'b0}},
                       prim_raw[NP-`TRGSUP_N_FPASYNC-1:0]};
      prim_sync_ff <= {prim_raw[NP-1:NP-`TRGSUP_N_FPASYNC],
                       prim_meta_ff[NP-`TRGSUP_N_FPASYNC-1:0]};
      prim_prev_ff <= prim_sync_ff;
    end
  end

  wire pm_busy     = sync_ff[`TRGSUP_N_FPASYNC+2];
  wire pm_inhibit  = sync_ff[`TRGSUP_N_FPASYNC+1];
  wire pm_pulse    = sync_ff[`TRGSUP_N_FPASYNC];
  wire pm_cal      = sync_ff[`TRGSUP_N_FPASYNC+3];
  wire pm_fixed    = sync_ff[`TRGSUP_N_FPASYNC+4];
  wire pm_sync     = sync_ff[`TRGSUP_N_FPASYNC+5];
  wire pm_clk_ext  = sync_ff[`TRGSUP_N_FPASYNC+6];
  reg  cal_prev_ff;
  reg  fixed_prev_ff;
  reg  sync_prev_ff;

  assign prim_edge = prim_sync_ff & ~prim_prev_ff & i_prim_enable;

  // Per-primitive prescaler: pass one edge in every i_prescale+1
  genvar g;
  generate
    for (g = 0; g < NP; g = g + 1) begin : g_ps
      reg [`TRGSUP_PS_W-1:0] cnt_ff;
      assign prim_ps[g] = prim_edge[g] & (cnt_ff == i_prescale);
      always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          cnt_ff <= {`TRGSUP_PS_W{1'b0}};
        end else if (prim_edge[g]) begin
          cnt_ff <= (cnt_ff == i_prescale) ? {`TRGSUP_PS_W{1'b0}}
                    : cnt_ff + 1'b1;
        end
      end
    end
  endgenerate

  // Random trigger source
  reg [15:0] lfsr_ff;
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lfsr_ff <= `TRGSUP_LFSR_SEED;
    end else begin
      lfsr_ff <= {lfsr_ff[14:0],
                  lfsr_ff[15] ^ lfsr_ff[13] ^ lfsr_ff[12] ^ lfsr_ff[10]};
    end
  end
  wire rand_hit = i_rand_enable & (lfsr_ff < i_rand_thresh);

  // Fixed-count generator
  reg        fx_state_ff;
  reg [15:0] fx_left_ff;
  wire       fixed_req = (fx_state_ff == FX_RUN);

  wire cal_req = pm_cal & ~cal_prev_ff;

  // Source priority: calibration, global, fp sync, fp async, fixed, random
  wire glb_hit = |prim_ps[`TRGSUP_N_GLOBAL-1:0];
  wire fps_hit = |prim_ps[`TRGSUP_N_GLOBAL+`TRGSUP_N_FPSYNC-1:
                          `TRGSUP_N_GLOBAL];
  wire fpa_hit = |prim_ps[NP-1:`TRGSUP_N_GLOBAL+`TRGSUP_N_FPSYNC];
  reg  [`TRGSUP_SRC_W-1:0] src;
  reg                       req;
  always @* begin
    req = 1'b1;
    src = `TRGSUP_SRC_CAL;
    if (cal_req) begin
      src = `TRGSUP_SRC_CAL;
    end else if (glb_hit) begin
      src = `TRGSUP_SRC_GLOBAL;
    end else if (fps_hit) begin
      src = `TRGSUP_SRC_FPSYNC;
    end else if (fpa_hit) begin
      src = `TRGSUP_SRC_FPASYNC;
    end else if (fixed_req) begin
      src = `TRGSUP_SRC_FIXED;
    end else if (rand_hit) begin
      src = `TRGSUP_SRC_RAND;
    end else begin
      req = 1'b0;
    end
  end

  // Busy hold-off: limit rate or stop entirely
  reg  [15:0] hold_ff;
  wire        fifo_in_ready;
  wire        busy_block = pm_busy & (i_busy_stop | (hold_ff != 16'h0000));
  wire        suppressed = pm_inhibit | busy_block;
  wire        accept     = req & ~suppressed & fifo_in_ready;
  wire        fixed_take = fixed_req & accept &
                           (src == `TRGSUP_SRC_FIXED);

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fx_state_ff   <= FX_IDLE;
      fx_left_ff    <= 16'h0000;
      cal_prev_ff   <= 1'b0;
      fixed_prev_ff <= 1'b0;
      sync_prev_ff  <= 1'b0;
      hold_ff       <= 16'h0000;
    end else begin
      cal_prev_ff   <= pm_cal;
      fixed_prev_ff <= pm_fixed;
      sync_prev_ff  <= pm_sync;
      case (fx_state_ff)
        FX_IDLE: begin
          if (pm_fixed & ~fixed_prev_ff & (i_fixed_count != 16'h0000)) begin
            fx_state_ff <= FX_RUN;
            fx_left_ff  <= i_fixed_count;
          end
        end
        FX_RUN: begin
          if (fixed_take) begin
            fx_left_ff <= fx_left_ff - 16'h0001;
            if (fx_left_ff == 16'h0001) begin
              fx_state_ff <= FX_IDLE;
            end
          end
        end
        default: begin
          fx_state_ff <= FX_IDLE;
        end
      endcase
      if (accept & pm_busy) begin
        hold_ff <= i_busy_hold;
      end else if (hold_ff != 16'h0000) begin
        hold_ff <= hold_ff - 16'h0001;
      end
    end
  end

  // Slot divider for the 62.5 MHz word rate
  reg [`TRGSUP_SER_DIV_W-1:0] div_ff;
  wire slot_en = (div_ff == SER_DIV[`TRGSUP_SER_DIV_W-1:0] - 1'b1);
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_ff <= {`TRGSUP_SER_DIV_W{1'b0}};
    end else begin
      div_ff <= slot_en ? {`TRGSUP_SER_DIV_W{1'b0}} : div_ff + 1'b1;
    end
  end

  // Trigger word: header, source, type
  wire sync_req  = pm_sync & ~sync_prev_ff;
  wire [15:0] trig_word = {`TRGSUP_HDR_TRIG, src, i_trig_type};
  wire [15:0] sync_word = {`TRGSUP_HDR_SYNC, 11'h000};
  wire        push      = accept | sync_req;
  wire [15:0] push_word = sync_req ? sync_word : trig_word;

  wire        fifo_out_valid;
  wire [15:0] fifo_out_data;
  wire        ser_ready;
  wire [3:0]  ser_nib;
  wire        ser_frame;

  trgsup_fifo #(
    .WIDTH (`TRGSUP_WORD_W),
    .DEPTH (`TRGSUP_FIFO_DEPTH),
    .AW    (`TRGSUP_FIFO_AW)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_rst_n     (i_rst_n),
    .i_in_valid  (push),
    .i_in_data   (push_word),
    .o_in_ready  (fifo_in_ready),
    .o_out_valid (fifo_out_valid),
    .o_out_data  (fifo_out_data),
    .i_out_ready (ser_ready)
  );

  trgsup_ser u_ser (
    .i_clk        (i_clk),
    .i_rst_n      (i_rst_n),
    .i_slot_en    (slot_en),
    .i_word_valid (fifo_out_valid),
    .i_word       (fifo_out_data),
    .o_word_ready (ser_ready),
    .o_ser_nib    (ser_nib),
    .o_ser_frame  (ser_frame)
  );

  // Backplane pulse stretcher
  reg [`TRGSUP_PULSE_CYC_W-1:0] bp_cnt_ff;

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ser_nib       <= 4'h0;
      o_ser_frame     <= 1'b0;
      o_align_pulse   <= 1'b0;
      o_clk_sel_ext   <= 1'b0;
      o_bp_trig_pulse <= 1'b0;
      bp_cnt_ff       <= {`TRGSUP_PULSE_CYC_W{1'b0}};
      o_trig_event    <= 1'b0;
      o_trig_lost     <= 1'b0;
      o_fifo_full     <= 1'b0;
      o_dead_count    <= 32'h00000000;
      o_event_count   <= 32'h00000000;
    end else begin
      o_ser_nib     <= ser_nib;
      o_ser_frame   <= ser_frame;
      o_align_pulse <= sync_req & fifo_in_ready;
      o_clk_sel_ext <= pm_clk_ext;
      if (accept & pm_pulse) begin
        bp_cnt_ff <= `TRGSUP_PULSE_CYC;
      end else if (bp_cnt_ff != {`TRGSUP_PULSE_CYC_W{1'b0}}) begin
        bp_cnt_ff <= bp_cnt_ff - 1'b1;
      end
      o_bp_trig_pulse <= (accept & pm_pulse) |
                         (bp_cnt_ff > {{(`TRGSUP_PULSE_CYC_W-1){1'b0}}, 1'b1});
      o_trig_event  <= accept & ~sync_req;
      o_trig_lost   <= req & ~(accept & ~sync_req);
      o_fifo_full   <= ~fifo_in_ready;
      if (suppressed) begin
        o_dead_count <= o_dead_count + 32'h00000001;
      end
      if (accept & ~sync_req) begin
        o_event_count <= o_event_count + 32'h00000001;
      end
    end
  end
endmodule // trgsup_core

// ### src/trgsup_fifo.v
// Trigger word FIFO, parameterised width and depth.
// Assumes one clock, asynchronous active-low reset.
`timescale 1ns/10ps
module trgsup_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // Clock and reset
  input  wire             i_clk,
  input  wire             i_rst_n,
  // Fill side
  input  wire             i_in_valid,
  input  wire [WIDTH-1:0] i_in_data,
  output wire             o_in_ready,
  // Drain side
  output wire             o_out_valid,
  output reg  [WIDTH-1:0] o_out_data,
  input  wire             i_out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_ff;
  reg [AW-1:0]    rd_ptr_ff;
  reg [AW:0]      count_ff;
  wire            push;
  wire            pop;

  assign o_in_ready  = (count_ff != DEPTH[AW:0]);
  assign o_out_valid = (count_ff != {(AW+1){1'b0}});
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;

  always @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr_ff] <= i_in_data;
    end
  end

  always @* begin
    o_out_data = mem[rd_ptr_ff];
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      count_ff  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                     : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                     : rd_ptr_ff + 1'b1;
      end
      if (push & ~pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (pop & ~push) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end
endmodule // trgsup_fifo

// ### src/trgsup_ser.v
// Trigger word serializer: 16 bits per 62.5 MHz slot, msb first.
// Assumes a one-cycle enable every fourth system clock.
`timescale 1ns/10ps
module trgsup_ser (
  // Clock and reset
  input  wire        i_clk,
  input  wire        i_rst_n,
  // Slot enable and word source
  input  wire        i_slot_en,
  input  wire        i_word_valid,
  input  wire [15:0] i_word,
  output reg         o_word_ready,
  // Serial out, four bits per system cycle
  output reg  [3:0]  o_ser_nib,
  output reg         o_ser_frame
);
  reg [15:0] shift_ff;

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      shift_ff     <= 16'h0000;
      o_ser_nib    <= 4'h0;
      o_ser_frame  <= 1'b0;
      o_word_ready <= 1'b0;
    end else begin
      o_word_ready <= 1'b0;
      if (i_slot_en) begin
        // New word each slot, idle zeros when empty
        shift_ff     <= i_word_valid ? {i_word[11:0], 4'h0} : 16'h0000;
        o_ser_nib    <= i_word_valid ? i_word[15:12] : 4'h0;
        o_ser_frame  <= 1'b1;
        o_word_ready <= i_word_valid;
      end else begin
        o_ser_nib   <= shift_ff[15:12];
        shift_ff    <= {shift_ff[11:0], 4'h0};
        o_ser_frame <= 1'b0;
      end
    end
  end
endmodule // trgsup_ser

// ### verif/trgsup_core_asserts.sv
// Port-level checker for the trigger supervisor core.
// Assumes a bind onto trgsup_core; sees only its ports.
`timescale 1ns/10ps
module trgsup_core_asserts (
  input wire        i_clk,
  input wire        i_rst_n,
  input wire        i_inhibit,
  input wire        i_busy,
  input wire        i_pulse_mode,
  input wire        i_clk_src_ext,
  input wire [3:0]  o_ser_nib,
  input wire        o_ser_frame,
  input wire        o_align_pulse,
  input wire        o_clk_sel_ext,
  input wire        o_bp_trig_pulse,
  input wire        o_trig_event,
  input wire        o_fifo_full,
  input wire [31:0] o_dead_count,
  input wire [31:0] o_event_count
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_quiet;
    !i_inhibit && !i_busy && !o_fifo_full;
  endsequence
  sequence s_frame_gap;
    !o_ser_frame [*3] ##1 o_ser_frame;
  endsequence
  // Sync word: all-ones top nibble, then zeros
  sequence s_sync_word;
    o_ser_frame && o_ser_nib == 4'hf ##1 (o_ser_nib == 4'h0) [*3];
  endsequence
  a_frame_period: assert property (
    o_ser_frame |=> s_frame_gap)
    else $error("frame marker not every fourth cycle");
  a_inhibit_blocks: assert property (
    i_inhibit [*6] |-> !o_trig_event)
    else $error("trigger passed while inhibited");
  a_dead_counts: assert property (
    i_inhibit [*6] |-> o_dead_count == $past(o_dead_count) + 32'h1)
    else $error("dead count not stepping");
  a_dead_holds: assert property (
    s_quiet [*6] |-> $stable(o_dead_count))
    else $error("dead count moved while live");
  a_event_count: assert property (
    o_event_count == $past(o_event_count) + {31'h0, o_trig_event})
    else $error("event count off");
  a_bp_length: assert property (
    $rose(o_bp_trig_pulse) |-> o_bp_trig_pulse [*4] ##1 !o_bp_trig_pulse)
    else $error("backplane pulse length wrong");
  a_bp_mode_off: assert property (
    !i_pulse_mode [*8] |-> !o_bp_trig_pulse)
    else $error("backplane pulse outside pulse mode");
  a_sync_word: assert property (
    o_align_pulse |-> ##[1:12] s_sync_word)
    else $error("sync word missing after alignment pulse");
  a_align_single: assert property (
    o_align_pulse |=> !o_align_pulse)
    else $error("alignment pulse too long");
  a_clk_ext_sel: assert property (
    i_clk_src_ext [*5] |-> o_clk_sel_ext)
    else $error("external clock not selected");
  a_clk_osc_sel: assert property (
    !i_clk_src_ext [*5] |-> !o_clk_sel_ext)
    else $error("oscillator not selected");
  a_reset_quiet: assert property (
    $rose(i_rst_n) |-> o_dead_count == 32'h0 && o_event_count == 32'h0)
    else $error("counters not cleared by reset");
endmodule // trgsup_core_asserts

bind trgsup_core trgsup_core_asserts u_asserts (.*);

// ### verif/trgsup_fe_model.sv
// Front-end interface model: rebuilds words, raises busy when nearly full.
// Assumes nibble stream and frame marker straight from trgsup_core.
`timescale 1ns/10ps
`include "trgsup_consts.vh"
module trgsup_fe_model #(
  parameter ALMOST = 2
) (
  // Clock and reset
  input  wire        i_clk,
  input  wire        i_rst_n,
  // Serial stream and buffer read
  input  wire [3:0]  i_ser_nib,
  input  wire        i_ser_frame,
  input  wire        i_read,
  // Rebuilt words and busy
  output reg  [15:0] o_word,
  output reg         o_word_stb,
  output wire        o_busy
);
  reg  [11:0] acc_ff;
  reg  [1:0]  pos_ff;
  reg  [3:0]  fill_ff;
  wire [15:0] word;
  wire        inc;
  wire        dec;
  assign word = {acc_ff, i_ser_nib};
  assign inc = (pos_ff == 2'h3) && (word[15:11] == `TRGSUP_HDR_TRIG);
  assign dec = i_read && (fill_ff != 4'h0);
  // Nearly full event buffer asks for a pause
  assign o_busy = (fill_ff >= ALMOST);
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      acc_ff <= 12'h0;
      pos_ff <= 2'h0;
      fill_ff <= 4'h0;
      o_word <= 16'h0;
      o_word_stb <= 1'b0;
    end else begin
      acc_ff <= {acc_ff[7:0], i_ser_nib};
      if (i_ser_frame)
        pos_ff <= 2'h1;
      else if (pos_ff != 2'h0)
        pos_ff <= pos_ff + 2'h1;
      o_word_stb <= (pos_ff == 2'h3) && (word != 16'h0);
      if (pos_ff == 2'h3)
        o_word <= word;
      fill_ff <= fill_ff + {3'h0, inc} - {3'h0, dec};
    end
  end
endmodule // trgsup_fe_model

// ### verif/trgsup_tb.sv
// Self-checking bench for trgsup_core with a front-end model.
// Assumes the checker is bound from its own file.
`timescale 1ns/10ps
`include "trgsup_consts.vh"
module testbench;
  reg         clk, rst_n, cal, fix_go, sync_cmd, busy_stop;
  reg         inhibit, clk_ext, pmode, rd, seen, rand_en;
  reg  [29:0] g_trig, s_trig;
  reg  [14:0] a_trig;
  reg  [74:0] prim_en;
  reg  [7:0]  ttype;
  reg  [15:0] prescale, fix_n, hold;
  reg  [15:0] wq[$];
  reg  [31:0] d0;
  wire [3:0]  nib;
  wire        frame, align, sel_ext, bp, ev, lost, full, busy, stb;
  wire [31:0] dead, evcnt;
  wire [15:0] word;
  integer     fail_count, comparisons, i, n, e0, l0;
  integer     ev_n, lost_n, align_n, bp_n;

  always #2 clk = ~clk;

  trgsup_core u_dut (
    .i_clk(clk), .i_rst_n(rst_n),
    .i_global_trig(g_trig), .i_global_clk(2'h0),
    .i_fpsync_trig(s_trig), .i_fpsync_clk(2'h0),
    .i_fpasync_trig(a_trig), .i_prim_enable(prim_en),
    .i_prescale(prescale), .i_trig_type(ttype),
    .i_cal_cmd(cal), .i_rand_enable(rand_en), .i_rand_thresh(16'hffff),
    .i_fixed_start(fix_go), .i_fixed_count(fix_n),
    .i_sync_cmd(sync_cmd), .i_busy(busy), .i_busy_stop(busy_stop),
    .i_busy_hold(hold), .i_inhibit(inhibit),
    .i_clk_src_ext(clk_ext), .i_pulse_mode(pmode),
    .o_ser_nib(nib), .o_ser_frame(frame), .o_align_pulse(align),
    .o_clk_sel_ext(sel_ext), .o_bp_trig_pulse(bp),
    .o_trig_event(ev), .o_trig_lost(lost), .o_fifo_full(full),
    .o_dead_count(dead), .o_event_count(evcnt)
  );

  trgsup_fe_model u_fe (
    .i_clk(clk), .i_rst_n(rst_n), .i_ser_nib(nib),
    .i_ser_frame(frame), .i_read(rd), .o_word(word),
    .o_word_stb(stb), .o_busy(busy)
  );

  // Tally high cycles of the pulse outputs and rebuilt words
  always @(negedge clk) begin
    if (ev === 1'b1) ev_n = ev_n + 1;
    if (lost === 1'b1) lost_n = lost_n + 1;
    if (align === 1'b1) align_n = align_n + 1;
    if (bp === 1'b1) bp_n = bp_n + 1;
    if (stb === 1'b1) wq.push_back(word);
  end

  task final_report;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask

  task give_up;
    begin
      fail_count = fail_count + 1;
      $display("Error wait expected done seen timeout");
      final_report;
    end
  endtask

  task chk(input [8*10:1] nm, input [31:0] exp, input [31:0] got);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("Error %0s expected %h seen %h", nm, exp, got);
      end
    end
  endtask

  task hit(input integer g, input integer b);
    begin
      @(negedge clk);
      case (g)
        0: g_trig[b] = 1'b1;
        1: s_trig[b] = 1'b1;
        default: a_trig[b] = 1'b1;
      endcase
      repeat (4) @(negedge clk);
      g_trig = 30'h0;
      s_trig = 30'h0;
      a_trig = 15'h0;
    end
  endtask

  task expect_word(input [15:0] exp);
    begin
      for (n = 0; n < 60 && wq.size() == 0; n = n + 1)
        @(negedge clk);
      if (wq.size() == 0) give_up;
      chk("word", {16'h0, exp}, {16'h0, wq.pop_front()});
    end
  endtask

  task t_sources;
    begin
      for (i = 0; i < 3; i = i + 1) begin
        ttype = 8'ha0 + i[7:0];
        hit(i, 7);
        expect_word({`TRGSUP_HDR_TRIG, i[2:0] + `TRGSUP_SRC_GLOBAL, ttype});
      end
      cal = 1'b1;
      repeat (4) @(negedge clk);
      cal = 1'b0;
      expect_word({`TRGSUP_HDR_TRIG, `TRGSUP_SRC_CAL, ttype});
      @(negedge clk);
      rand_en = 1'b1;
      @(negedge clk);
      rand_en = 1'b0;
      expect_word({`TRGSUP_HDR_TRIG, `TRGSUP_SRC_RAND, ttype});
      $display("done sources");
    end
  endtask

  task t_prescale;
    begin
      prescale = 16'h1;
      e0 = ev_n;
      for (i = 0; i < 4; i = i + 1)
        hit(0, 3);
      prim_en[3] = 1'b0;
      hit(0, 3);
      repeat (20) @(negedge clk);
      chk("prescaled", e0 + 2, ev_n);
      prescale = 16'h0;
      prim_en[3] = 1'b1;
      wq.delete();
      $display("done prescale");
    end
  endtask

  task t_fixed;
    begin
      fix_n = 16'h3;
      fix_go = 1'b1;
      repeat (4) @(negedge clk);
      fix_go = 1'b0;
      for (i = 0; i < 3; i = i + 1)
        expect_word({`TRGSUP_HDR_TRIG, `TRGSUP_SRC_FIXED, ttype});
      repeat (20) @(negedge clk);
      chk("fixed", 32'h0, wq.size());
      $display("done fixed");
    end
  endtask

  task t_inhibit;
    begin
      inhibit = 1'b1;
      e0 = ev_n;
      l0 = lost_n;
      repeat (4) @(negedge clk);
      d0 = dead;
      hit(0, 9);
      repeat (5) @(negedge clk);
      chk("dead", d0 + 32'ha, dead);
      chk("inh lost", l0 + 1, lost_n);
      chk("inh event", e0, ev_n);
      inhibit = 1'b0;
      $display("done inhibit");
    end
  endtask

  task t_busy;
    begin
      rd = 1'b0;
      busy_stop = 1'b1;
      hit(0, 1);
      hit(0, 2);
      for (n = 0; n < 60 && busy !== 1'b1; n = n + 1)
        @(negedge clk);
      if (busy !== 1'b1) give_up;
      repeat (3) @(negedge clk);
      e0 = ev_n;
      l0 = lost_n;
      hit(1, 4);
      repeat (5) @(negedge clk);
      chk("busy event", e0, ev_n);
      chk("busy lost", l0 + 1, lost_n);
      busy_stop = 1'b0;
      hold = 16'h0040;
      e0 = ev_n;
      l0 = lost_n;
      hit(1, 5);
      hit(1, 6);
      repeat (5) @(negedge clk);
      chk("rate event", e0 + 1, ev_n);
      chk("rate lost", l0 + 1, lost_n);
      rd = 1'b1;
      for (n = 0; n < 20 && busy !== 1'b0; n = n + 1)
        @(negedge clk);
      if (busy !== 1'b0) give_up;
      repeat (3) @(negedge clk);
      wq.delete();
      hit(1, 4);
      expect_word({`TRGSUP_HDR_TRIG, `TRGSUP_SRC_FPSYNC, ttype});
      $display("done busy");
    end
  endtask

  task t_sync;
    begin
      e0 = align_n;
      sync_cmd = 1'b1;
      repeat (4) @(negedge clk);
      sync_cmd = 1'b0;
      expect_word({`TRGSUP_HDR_SYNC, 11'h0});
      chk("align", e0 + 1, align_n);
      $display("done sync");
    end
  endtask

  task t_fill;
    begin
      e0 = ev_n;
      l0 = lost_n;
      seen = 1'b0;
      wq.delete();
      for (i = 0; i < 24; i = i + 1) begin
        @(negedge clk);
        g_trig = 30'h1 << i;
        if (full === 1'b1) seen = 1'b1;
      end
      @(negedge clk);
      g_trig = 30'h0;
      for (n = 0; n < 200 && wq.size() != ev_n - e0; n = n + 1)
        @(negedge clk);
      chk("full seen", 32'h1, {31'h0, seen});
      chk("requests", 24, (ev_n - e0) + (lost_n - l0));
      chk("drained", ev_n - e0, wq.size());
      chk("evcnt", ev_n, evcnt);
      $display("done fill");
    end
  endtask

  task t_mode;
    begin
      clk_ext = 1'b1;
      pmode = 1'b1;
      repeat (5) @(negedge clk);
      chk("clk ext", 32'h1, {31'h0, sel_ext});
      e0 = bp_n;
      hit(2, 0);
      repeat (10) @(negedge clk);
      chk("bp cycles", e0 + 4, bp_n);
      clk_ext = 1'b0;
      pmode = 1'b0;
      repeat (5) @(negedge clk);
      chk("clk osc", 32'h0, {31'h0, sel_ext});
      $display("done modes");
    end
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    give_up;
  end

  initial begin
    {fail_count, comparisons, ev_n, lost_n, align_n, bp_n} = 0;
    {clk, rst_n, cal, fix_go, sync_cmd, busy_stop} = 6'h0;
    {inhibit, clk_ext, pmode, rand_en} = 4'h0;
    rd = 1'b1;
    {g_trig, s_trig, a_trig} = 75'h0;
    prim_en = {75{1'b1}};
    ttype = 8'h5a;
    prescale = 16'h0;
    fix_n = 16'h0;
    hold = 16'h0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    chk("dead rst", 32'h0, dead);
    t_sources;
    t_prescale;
    t_fixed;
    t_inhibit;
    t_busy;
    t_sync;
    t_fill;
    t_mode;
    final_report;
  end
endmodule // testbench
